// ===== shared/npic_params.svh
`ifndef NPIC_PARAMS_SVH
`define NPIC_PARAMS_SVH
// register byte addresses on the bus
`define NPIC_ADDR_PRIO0 8'h00
`define NPIC_ADDR_PRIO1 8'h04
`define NPIC_ADDR_PRIO2 8'h08
`define NPIC_ADDR_PRIO3 8'h0C
`define NPIC_ADDR_FLAGS 8'h10
`define NPIC_ADDR_PEND 8'h14
`define NPIC_ADDR_CTRL 8'h18
`define NPIC_ADDR_STAT 8'h1C
`define NPIC_PRIO_RESET 8'hFF
`define NPIC_PRIO3_RO_MASK 8'hF0
`define NPIC_FLAGS_RESET 8'hEA
`define NPIC_BIT_UPPER 5
`define NPIC_BIT_LOWER 3
`define NPIC_LVL0 2'b10
`define NPIC_LVL1 2'b01
`define NPIC_LVL2 2'b00
`define NPIC_LVL3 2'b11
`define NPIC_VEC_BASE 16'hFFE0
`define NPIC_VEC_TRAP 16'hFFFC
`define NPIC_VEC_RESET 16'hFFFE
`define NPIC_NVEC 14
`define NPIC_NGRP 4
`endif

// ===== shared/npic_pkg.sv
package npic_pkg;
  // one hardware vector index, 0 = top-level pin (highest), 13 lowest
  typedef logic [3:0] npic_vec_t;
  typedef logic [1:0] npic_code_t;
  typedef enum logic [2:0] {NPIC_RUN, NPIC_WAITING, NPIC_HALTED} npic_mode_e;
  // instruction strobes from the sequencer
  typedef struct packed {
    logic halt;
    logic wait_for_irq_instr;
    logic irq_enable_instr;
    logic sim;
    logic trap;
    logic isr_return_instr;
    logic pop_flags;
    logic [7:0] pop_value;
  } npic_instr_s;
  // service answer to the core
  typedef struct packed {
    logic take;
    logic [15:0] vector;
    logic stack;
  } npic_svc_s;
endpackage

// ===== verilog/npic_ctrl.sv
// Notes on behaviour
// - pick highest software level, ties broken by fixed hardware order
// - unserviced requests stay latched until they win arbitration
// - reset, trap and top-level pin rank above every software level
// - non-maskable ignore level bits; stack except reset, load vector, set level 3
// - non-maskable sources wake from halt
// - trap serviced like top-level, top-level may preempt it; no trap in its handler
// - reset has top priorities, code after reset runs at level 3
// - maskable serviced only if enabled and level strictly above current
// - top-level request raised on selected edge of its pin
// - edge external requests latched, cleared on entering their handler
// - pins of one group sharing a line are ORed
// - peripheral request only while its flag and enable are set
// - peripheral clear sequence drops its latched request
// - all wake from wait; only halt-capable wake halt and are served first
// - hardware order rises main, vectors 13..1, then top-level; nesting preempts
// - level held in flag bits 5 and 3: 10,01,00,11 for levels 0..3
// - maskable entry loads level from the vector's priority pair
// - four priority registers reset to ones, two bits each; top nibble fixed
// - a written level-0 pair is ignored, other pairs update
// - top-level pair stored but unused; reset, trap, top-level set level 3
// - raised priority of a still-pending running vector re-enters it
// - halt, wfi, rim load 10; sim, trap 11; return and pop restore
// - vectors sit from FFE0 upward in hardware order
// - service only after the current instruction completes, then stack
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "npic_params.svh"
module npic_ctrl
  import npic_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // sources: vec 0 is the top-level pin, 1..3 external pin groups 1..3, group 0 ORed into vec 4, others peripheral
  input wire logic tli_pin,
  input wire logic [`NPIC_NGRP*2-1:0] ext_pins,
  input wire logic [`NPIC_NVEC-1:0] periph_flag,
  input wire logic [`NPIC_NVEC-1:0] periph_en,
  input wire logic [`NPIC_NVEC-1:0] periph_clear,
  input wire logic [`NPIC_NVEC-1:0] halt_capable,
  // core sequencer
  input wire logic instr_done,
  input wire npic_instr_s instr,
  output npic_svc_s svc,
  output logic [7:0] flags_out,
  output logic masked,
  output logic cpu_wake
);
  logic [7:0] prio_r [0:3];
  logic [7:0] flags_r;
  logic [1:0] ctrl_r;
  logic [`NPIC_NVEC-1:0] pend_r;
  npic_mode_e mode_r;
  logic trap_pend_r;
  logic tli_s1_r, tli_s2_r, tli_s3_r;
  logic [`NPIC_NGRP*2-1:0] ext_s1_r, ext_s2_r, ext_s3_r;
  logic [`NPIC_NGRP-1:0] grp_rise;
  logic tli_edge;
  logic [`NPIC_NVEC-1:0] raw_req;
  logic [1:0] cur_lvl;
  logic wr_en, rd_en;
  logic [31:0] rdata_nxt;
  logic win_valid;
  npic_vec_t win_vec;
  logic [1:0] win_lvl;
  logic take_nmi, take_mask;
  logic [`NPIC_NVEC-1:0] served;

  // level code to rank, level 3 highest
  function automatic logic [1:0] npic_rank(input logic [1:0] c);
    unique case (c)
      `NPIC_LVL0: npic_rank = 2'd0;
      `NPIC_LVL1: npic_rank = 2'd1;
      `NPIC_LVL2: npic_rank = 2'd2;
      `NPIC_LVL3: npic_rank = 2'd3;
    endcase
  endfunction

  function automatic logic [1:0] vec_code(input int v);
    vec_code = prio_r[v/4][(v%4)*2 +: 2];
  endfunction

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign cur_lvl = {flags_r[`NPIC_BIT_UPPER], flags_r[`NPIC_BIT_LOWER]};
  assign tli_edge = ctrl_r[0] && (ctrl_r[1] ? (tli_s2_r && !tli_s3_r) : (!tli_s2_r && tli_s3_r));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tli_s1_r <= 1'b0;
      tli_s2_r <= 1'b0;
      tli_s3_r <= 1'b0;
      ext_s1_r <= '0;
      ext_s2_r <= '0;
      ext_s3_r <= '0;
    end
    else
    begin
      tli_s1_r <= tli_pin;
      tli_s2_r <= tli_s1_r;
      tli_s3_r <= tli_s2_r;
      ext_s1_r <= ext_pins;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end

  // group pins ORed onto one line
  genvar g;
  generate
    for (g = 0; g < `NPIC_NGRP; g++)
    begin : g_grp
      assign grp_rise[g] = |(ext_s2_r[g*2 +: 2] & ~ext_s3_r[g*2 +: 2]);
    end
  endgenerate

  // peripheral request needs flag and enable
  always_comb
  begin
    raw_req = periph_flag & periph_en;
    raw_req[0] = tli_edge;
    raw_req[`NPIC_NGRP-1:1] = grp_rise[`NPIC_NGRP-1:1];
    raw_req[`NPIC_NGRP] = raw_req[`NPIC_NGRP] | grp_rise[0];
  end

  // two-step arbitration; scanning from lowest hardware priority upward, >= lets higher vector win ties
  always_comb
  begin
    win_valid = 1'b0;
    win_vec = 4'h0;
    win_lvl = 2'd0;
    for (int v = `NPIC_NVEC-1; v >= 0; v--)
    begin
      // in halt only halt-capable requests and the top-level pin compete
      if (pend_r[v] && (mode_r != NPIC_HALTED || halt_capable[v] || v == 0))
      begin
        // top-level ranks above every software level
        // its stored pair is not used
        if (v == 0)
        begin
          win_valid = 1'b1;
          win_vec = 4'h0;
          win_lvl = 2'd3;
        end
        else if (!win_valid || npic_rank(vec_code(v)) >= win_lvl)
        begin
          win_valid = 1'b1;
          win_vec = npic_vec_t'(v);
          win_lvl = npic_rank(vec_code(v));
        end
      end
    end
  end

  // trap ignores level bits; top-level preempts a level-3 trap routine
  assign take_nmi = instr_done && trap_pend_r && !(win_valid && win_vec == 4'h0);
  // strictly higher than current, top-level always allowed
  // re-entry falls out of comparing live priority pair
  assign take_mask = instr_done && win_valid && (win_vec == 4'h0 || win_lvl > npic_rank(cur_lvl))
                     && (win_vec == 4'h0 || !trap_pend_r);

  always_comb
  begin
    served = '0;
    if (take_mask)
      served[win_vec] = 1'b1;
  end

  // cleared on entering handler; new event same cycle wins
  // clear sequence discards pending peripheral request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pend_r <= '0;
    else
      pend_r <= raw_req | (pend_r & ~served & ~periph_clear);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      trap_pend_r <= 1'b0;
    else if (instr.trap)
      trap_pend_r <= 1'b1;
    else if (take_nmi)
      trap_pend_r <= 1'b0;
  end

  // any request ends wait, only capable ones, top-level or a pending trap end halt
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_r <= NPIC_RUN;
    else
    begin
      unique case (mode_r)
        NPIC_RUN:
          if (instr.halt)
            mode_r <= NPIC_HALTED;
          else if (instr.wait_for_irq_instr)
            mode_r <= NPIC_WAITING;
        NPIC_WAITING:
          if (win_valid || trap_pend_r)
            mode_r <= NPIC_RUN;
        NPIC_HALTED:
          if (win_valid || trap_pend_r)
            mode_r <= NPIC_RUN;
      endcase
    end
  end

  // top-level and trap entry set level 3
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flags_r <= `NPIC_FLAGS_RESET;
    else if (take_nmi || (take_mask && win_vec == 4'h0))
    begin
      flags_r[`NPIC_BIT_UPPER] <= 1'b1;
      flags_r[`NPIC_BIT_LOWER] <= 1'b1;
    end
    else if (take_mask)
    begin
      {flags_r[`NPIC_BIT_UPPER], flags_r[`NPIC_BIT_LOWER]} <= vec_code(int'(win_vec));
    end
    else if (instr.isr_return_instr || instr.pop_flags)
      flags_r <= instr.pop_value;
    else if (instr.sim || instr.trap)
    begin
      flags_r[`NPIC_BIT_UPPER] <= 1'b1;
      flags_r[`NPIC_BIT_LOWER] <= 1'b1;
    end
    else if (instr.halt || instr.wait_for_irq_instr || instr.irq_enable_instr)
    begin
      flags_r[`NPIC_BIT_UPPER] <= 1'b1;
      flags_r[`NPIC_BIT_LOWER] <= 1'b0;
    end
    else if (wr_en && paddr == `NPIC_ADDR_FLAGS)
      flags_r <= pwdata[7:0];
  end

  // written level-0 pairs keep old value
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int r = 0; r < 4; r++)
        prio_r[r] <= `NPIC_PRIO_RESET;
    end
    else if (wr_en && paddr[7:4] == 4'h0 && paddr[1:0] == 2'b00)
    begin
      for (int p = 0; p < 4; p++)
        if (pwdata[p*2 +: 2] != `NPIC_LVL0)
          prio_r[paddr[3:2]][p*2 +: 2] <= pwdata[p*2 +: 2];
      if (paddr[3:2] == 2'd3)
        prio_r[3][7:4] <= 4'hF;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_r <= 2'b00;
    else if (wr_en && paddr == `NPIC_ADDR_CTRL)
    begin
      ctrl_r[0] <= pwdata[0];
      // edge select only changes while disabled
      if (!ctrl_r[0])
        ctrl_r[1] <= pwdata[1];
    end
  end

  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    unique case (paddr)
      `NPIC_ADDR_PRIO0: rdata_nxt[7:0] = prio_r[0];
      `NPIC_ADDR_PRIO1: rdata_nxt[7:0] = prio_r[1];
      `NPIC_ADDR_PRIO2: rdata_nxt[7:0] = prio_r[2];
      `NPIC_ADDR_PRIO3: rdata_nxt[7:0] = prio_r[3] | `NPIC_PRIO3_RO_MASK;
      `NPIC_ADDR_FLAGS: rdata_nxt[7:0] = flags_r;
      `NPIC_ADDR_PEND: rdata_nxt[`NPIC_NVEC-1:0] = pend_r;
      `NPIC_ADDR_CTRL: rdata_nxt[1:0] = ctrl_r;
      `NPIC_ADDR_STAT: rdata_nxt[2:0] = {trap_pend_r, mode_r == NPIC_HALTED, mode_r == NPIC_WAITING};
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  // no wait state: data latched in setup, ready in first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && (paddr > `NPIC_ADDR_STAT || paddr[1:0] != 2'b00);
      if (rd_en)
        prdata <= rdata_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      svc <= '0;
      cpu_wake <= 1'b0;
    end
    else
    begin
      svc.take <= take_nmi || take_mask;
      svc.stack <= take_nmi || take_mask;
      if (take_nmi)
        svc.vector <= `NPIC_VEC_TRAP;
      else if (take_mask)
        svc.vector <= `NPIC_VEC_TRAP - 16'h0002 - {11'h000, win_vec, 1'b0};
      cpu_wake <= (mode_r != NPIC_RUN) && (win_valid || trap_pend_r);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flags_out <= `NPIC_FLAGS_RESET;
      masked <= 1'b1;
    end
    else
    begin
      flags_out <= flags_r;
      masked <= cur_lvl == `NPIC_LVL3;
    end
  end

  // maskable level not above current never taken; top-level excluded
  a_mask_strict: assert property (@(posedge pclk) disable iff (!presetn)
    (take_mask && win_vec != 4'h0) |-> (win_lvl > npic_rank(cur_lvl)))
    else $error("maskable taken at level not above current");
  a_entry_level: assert property (@(posedge pclk) disable iff (!presetn)
    (take_mask && win_vec != 4'h0 && !take_nmi) |=> (npic_rank(cur_lvl) == $past(win_lvl)))
    else $error("entry level not loaded from priority pair");
  a_nmi_level3: assert property (@(posedge pclk) disable iff (!presetn)
    take_nmi |=> (cur_lvl == `NPIC_LVL3 && svc.take && svc.vector == `NPIC_VEC_TRAP))
    else $error("trap entry wrong");
  a_rim_level0: assert property (@(posedge pclk) disable iff (!presetn)
    (instr.irq_enable_instr && !take_nmi && !take_mask && !instr.isr_return_instr && !instr.pop_flags && !instr.sim && !instr.trap)
    |=> cur_lvl == `NPIC_LVL0)
    else $error("enable instruction did not load level 0");
  a_pend_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (pend_r[5] && !served[5] && !periph_clear[5]) |=> pend_r[5])
    else $error("pending request lost");
  a_clear_drop: assert property (@(posedge pclk) disable iff (!presetn)
    (periph_clear[9] && !raw_req[9]) |=> !pend_r[9])
    else $error("clear sequence kept request");
  a_prio3_top: assert property (@(posedge pclk) disable iff (!presetn)
    prio_r[3][7:4] == 4'hF)
    else $error("read-only nibble changed");
  a_tli_wins: assert property (@(posedge pclk) disable iff (!presetn)
    pend_r[0] |-> (win_valid && win_vec == 4'h0))
    else $error("top-level did not win arbitration");
  a_halt_cap: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_r == NPIC_HALTED && win_valid && win_vec != 4'h0) |-> halt_capable[win_vec])
    else $error("non-capable chosen in halt");
endmodule

// ===== verification/npic_core_model.sv
`timescale 1ns/1ps
module npic_core_model
  import npic_pkg::*;
(
  // clock
  input wire logic pclk,
  // service answer
  input wire npic_svc_s svc,
  // sequencer side
  output logic instr_done,
  output npic_instr_s instr
);
  logic [16:0] taken_q[$];
  logic in_top = 1'b0;
  int slow = 3;
  int busy = 0;
  initial
  begin
    instr = '0;
    instr_done = 1'b1;
  end
  // stacking after an entry keeps the next boundary away for a while
  always @(posedge pclk)
  begin
    if (svc.take)
    begin
      taken_q.push_back({svc.stack, svc.vector});
      busy = slow;
    end
    else if (busy > 0)
      busy = busy - 1;
    instr_done <= (busy == 0) && !svc.take;
    if (svc.take)
      in_top <= svc.vector == 16'hFFFA;
    else if (instr.isr_return_instr)
      in_top <= 1'b0;
  end
  task automatic exec(input int code, input logic [7:0] val);
    npic_instr_s s;
    s = '0;
    s.pop_value = val;
    case (code)
      0: s.halt = 1'b1;
      1: s.wait_for_irq_instr = 1'b1;
      2: s.irq_enable_instr = 1'b1;
      3: s.sim = 1'b1;
      4: s.trap = !in_top;
      5: s.isr_return_instr = 1'b1;
      default: s.pop_flags = 1'b1;
    endcase
    instr <= s;
    @(posedge pclk);
    instr <= '0;
    // a following call must not re-drive the strobes in the same step
    @(posedge pclk);
  endtask
endmodule

// ===== verification/nested_priority_interrupt_ctrl_tb.sv
`timescale 1ns/1ps
module nested_priority_interrupt_ctrl_tb
  import npic_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, e;
  logic pready, pslverr, tli_pin, instr_done, masked, cpu_wake;
  logic [7:0] paddr, ext_pins, flags_out;
  logic [31:0] pwdata, prdata, q;
  logic [13:0] periph_flag, periph_en, periph_clear, halt_capable;
  npic_instr_s instr;
  npic_svc_s svc;
  int failures = 0;
  int compares = 0;
  int cyc = 0;

  npic_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tli_pin(tli_pin), .ext_pins(ext_pins), .periph_flag(periph_flag),
    .periph_en(periph_en), .periph_clear(periph_clear), .halt_capable(halt_capable),
    .instr_done(instr_done), .instr(instr), .svc(svc), .flags_out(flags_out),
    .masked(masked), .cpu_wake(cpu_wake));
  npic_core_model core (.pclk(pclk), .svc(svc), .instr_done(instr_done), .instr(instr));

  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic report_and_stop();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // the whole sequence needs a few hundred cycles
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      failures++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // only the bench timeout ends this wait
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so a following call never re-drives psel in the same step
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk(e, 0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
    chk(e, 0);
  endtask

  task automatic take(input logic [15:0] x);
    int n;
    n = 0;
    while (core.taken_q.size() == 0 && n < 40)
    begin
      n++;
      @(posedge pclk);
    end
    if (core.taken_q.size() == 0)
      chk(32'h0, {15'h0, 1'b1, x});
    else
      chk({15'h0, core.taken_q.pop_front()}, {15'h0, 1'b1, x});
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
    chk(core.taken_q.size(), 0);
  endtask

  task automatic lvl(input logic [1:0] x);
    repeat (2) @(posedge pclk);
    chk({flags_out[5], flags_out[3]}, x);
  endtask

  task automatic clr(input logic [13:0] m);
    periph_flag <= periph_flag & ~m;
    periph_clear <= m;
    @(posedge pclk);
    periph_clear <= '0;
  endtask

  initial
  begin
    {presetn, psel, penable, pwrite, tli_pin} = '0;
    {paddr, ext_pins, pwdata} = '0;
    {periph_flag, periph_clear, halt_capable} = '0;
    periph_en = '1;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 4; i++) rd(8'(4 * i), 32'hFF);
    rd(8'h10, 32'hEA);
    chk(masked, 1);
    apb(1'b0, 8'h20, 32'h0);
    chk(e, 1);
    wr(8'h00, 32'hCF);
    rd(8'h00, 32'hCF);
    wr(8'h00, 32'h64);
    rd(8'h00, 32'h44);
    wr(8'h0C, 32'h00);
    rd(8'h0C, 32'hF0);
    $display("test registers done");
    wr(8'h04, 32'hF7);
    wr(8'h08, 32'hFC);
    core.exec(2, 8'h00);
    lvl(2'b10);
    periph_flag <= 14'h0120;
    take(16'hFFEA);
    lvl(2'b00);
    idle(10);
    clr(14'h0100);
    core.exec(5, 8'hE2);
    take(16'hFFF0);
    lvl(2'b01);
    clr(14'h0020);
    core.exec(5, 8'hE2);
    periph_flag <= 14'h0440;
    take(16'hFFEE);
    idle(8);
    clr(14'h0040);
    core.exec(5, 8'hE2);
    take(16'hFFE6);
    clr(14'h0400);
    core.exec(5, 8'hE2);
    $display("test arbitration done");
    core.exec(3, 8'h00);
    lvl(2'b11);
    chk(masked, 1);
    periph_flag <= 14'h0200;
    idle(4);
    clr(14'h0200);
    core.exec(2, 8'h00);
    idle(10);
    chk(masked, 0);
    periph_en <= 14'h3DFF;
    periph_flag <= 14'h0200;
    idle(10);
    clr(14'h0200);
    periph_en <= '1;
    $display("test peripheral gating done");
    ext_pins <= 8'h08;
    take(16'hFFF8);
    core.exec(5, 8'hE2);
    idle(10);
    ext_pins <= 8'h28;
    take(16'hFFF6);
    core.exec(5, 8'hE2);
    ext_pins <= '0;
    $display("test external pins done");
    core.slow = 0;
    wr(8'h18, 32'h2);
    wr(8'h18, 32'h3);
    core.exec(4, 8'h00);
    take(16'hFFFC);
    lvl(2'b11);
    tli_pin <= 1'b1;
    take(16'hFFFA);
    core.exec(5, 8'hEA);
    core.exec(5, 8'hE2);
    tli_pin <= 1'b0;
    $display("test trap and top level done");
    wr(8'h08, 32'h7C);
    halt_capable <= 14'h0800;
    core.exec(0, 8'h00);
    periph_flag <= 14'h0200;
    idle(8);
    chk(cpu_wake, 0);
    rd(8'h1C, 32'h2);
    periph_flag <= 14'h0A00;
    take(16'hFFE4);
    take(16'hFFE8);
    clr(14'h0A00);
    core.exec(1, 8'h00);
    rd(8'h1C, 32'h1);
    periph_flag <= 14'h0200;
    take(16'hFFE8);
    $display("test halt exit done");
    report_and_stop();
  end
endmodule
